// ===== inc/setpoint_pkg.sv
// Package: setpoint detect engine constants, register map and carrier types
package setpoint_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int unsigned NUM_SETPOINTS = 16;
  localparam int unsigned NUM_CHANNELS = 64;
  localparam int unsigned NUM_DAC = 4;
  localparam int unsigned NUM_TIMER = 4;

  // ------------------------------------------------------------
  // Register map (word index)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_PORT_DATA = 8'h02;
  localparam logic [7:0] REG_DAC_BASE = 8'h04;
  localparam logic [7:0] REG_SP_BASE = 8'h10;
  localparam int unsigned SP_STRIDE_LOG2 = 3;
  localparam logic [2:0] SP_CFG = 3'h0;
  localparam logic [2:0] SP_LIMIT_HI = 3'h1;
  localparam logic [2:0] SP_LIMIT_LO = 3'h2;
  localparam logic [2:0] SP_VAL_TRUE = 3'h3;
  localparam logic [2:0] SP_VAL_FALSE = 3'h4;

  // Control register fields
  localparam int unsigned CTRL_ARM_BIT = 0;
  localparam int unsigned CTRL_PORT_OE_BIT = 1;

  // Setpoint config fields
  localparam int unsigned CFG_CHAN_LSB = 0;
  localparam int unsigned CFG_CRIT_LSB = 8;
  localparam int unsigned CFG_UPD_LSB = 11;
  localparam int unsigned CFG_ACT_LSB = 13;
  localparam int unsigned CFG_SEL_LSB = 15;
  localparam int unsigned CFG_EN_BIT = 17;

  // Reset values
  localparam logic [15:0] RST_DAC = 16'h0000;
  localparam logic [7:0] RST_PORT = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CRIT_EQUAL = 3'h0,
    CRIT_BELOW = 3'h1,
    CRIT_ABOVE = 3'h2,
    CRIT_INSIDE = 3'h3,
    CRIT_OUTSIDE = 3'h4,
    CRIT_HYST = 3'h5
  } crit_t;

  typedef enum logic [1:0] {
    UPD_NONE = 2'h0,
    UPD_TRUE_ONLY = 2'h1,
    UPD_TRUE_FALSE = 2'h2
  } upd_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_PORT = 2'h1,
    ACT_DAC = 2'h2,
    ACT_TIMER = 2'h3
  } act_t;

  typedef struct packed {
    logic en;
    logic [1:0] sel;
    act_t act;
    upd_t upd;
    crit_t crit;
    logic [7:0] chan;
  } sp_cfg_t;

  typedef struct packed {
    sp_cfg_t cfg;
    logic [15:0] limit_hi;
    logic [15:0] limit_lo;
    logic [15:0] val_true;
    logic [15:0] val_false;
  } sp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] chan;
    logic [15:0] data;
  } sample_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    logic [15:0] value;
  } timer_upd_t;
endpackage

// ===== rtl/setpoint_detect_update.sv
// Setpoint detection engine: compares scan samples to limits and forces output updates
// Operation
// - Up to sixteen setpoints, one per channel; the code lets several enabled setpoints share one chan
// - Each setpoint holds upper and lower limits
// - Equal/below use upper, above uses lower
// - Inside: strictly between lower and upper
// - Outside: above upper or below lower
// - Hysteresis: above forces value two, below one
// - Detect flag follows criterion per channel
// - True-only mode: act on true, else nothing
// - True-false mode: value one true, two false
// - Two sixteen-bit update values per setpoint
// - Action: none, port, analog, or timer
// - Update none: flag only, no output
// - Evaluate once per delivered channel sample
// - Detect flags returned as scan channels; the code gives them only on channel_match_flag and in the status register
// - Counter words each take own setpoint; the code has no counter words
// - Criterion states readable in status register
// - Port is input until software writes it
// - Analog outputs reset to zero volts
// - Evaluation starts when acquisition is armed
// - Port update changes only masked bits
// - Hysteresis holds outputs inside the window
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module setpoint_detect_update
  import setpoint_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire sample_t sample_in,
  output logic [NUM_SETPOINTS-1:0] channel_match_flag,
  output logic [7:0] byte_output_port,
  output logic [7:0] byte_output_port_oe,
  output logic [NUM_DAC-1:0][15:0] analog_output_n,
  output logic [NUM_DAC-1:0] analog_output_strobe,
  output timer_upd_t timer_update
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic armed;
    logic port_oe;
    logic [7:0] port;
    logic [NUM_DAC-1:0][15:0] dac;
    logic [NUM_DAC-1:0] dac_stb;
    timer_upd_t tmr;
    logic [NUM_SETPOINTS-1:0] flag;
    logic [NUM_SETPOINTS-1:0] hyst_hi;
    logic [NUM_SETPOINTS-1:0][15:0] hyst_seen;
    sp_t [NUM_SETPOINTS-1:0] sp;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ------------------------------------------------------------
  // Combinational next state
  // ------------------------------------------------------------
  always_comb begin
    logic [3:0] idx;
    logic [2:0] fld;
    logic hit;
    logic crit_ok;
    logic do_upd;
    logic [15:0] val;
    logic [15:0] x;
    sp_t s;
    st_nxt = st_r;
    idx = reg_addr[SP_STRIDE_LOG2+3:SP_STRIDE_LOG2];
    fld = reg_addr[2:0];
    hit = 1'b0;
    crit_ok = 1'b0;
    do_upd = 1'b0;
    val = 16'h0000;
    x = sample_in.data;
    s = st_r.sp[0];
    st_nxt.dac_stb = '0;
    st_nxt.tmr.valid = 1'b0;
    st_nxt.hyst_seen = st_r.hyst_seen;

    // Register writes; configuration meant to be set before arming
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        st_nxt.armed = reg_wdata[CTRL_ARM_BIT];
        st_nxt.port_oe = reg_wdata[CTRL_PORT_OE_BIT];
      end else if (reg_addr == REG_PORT_DATA) begin
        st_nxt.port = reg_wdata[7:0];
        st_nxt.port_oe = 1'b1;
      end else if (reg_addr >= REG_DAC_BASE && reg_addr < REG_DAC_BASE + 8'(NUM_DAC)) begin
        st_nxt.dac[reg_addr[1:0]] = reg_wdata[15:0];
        st_nxt.dac_stb[reg_addr[1:0]] = 1'b1;
      end else if (reg_addr[7:4] != 4'h0 && reg_addr >= REG_SP_BASE) begin
        idx = 4'(reg_addr - REG_SP_BASE >> SP_STRIDE_LOG2);
        if (idx < 4'(NUM_SETPOINTS - 1) || idx == 4'(NUM_SETPOINTS - 1)) begin
          unique case (fld)
            SP_CFG: st_nxt.sp[idx].cfg = sp_cfg_t'(reg_wdata[CFG_EN_BIT:0]);
            SP_LIMIT_HI: st_nxt.sp[idx].limit_hi = reg_wdata[15:0];
            SP_LIMIT_LO: st_nxt.sp[idx].limit_lo = reg_wdata[15:0];
            SP_VAL_TRUE: st_nxt.sp[idx].val_true = reg_wdata[15:0];
            SP_VAL_FALSE: st_nxt.sp[idx].val_false = reg_wdata[15:0];
            default: st_nxt.sp[idx] = st_r.sp[idx];
          endcase
        end
      end
    end

    // Evaluation, one sample per channel per scan; 16 setpoints max
    if (st_r.armed && sample_in.valid) begin
      for (int i = 0; i < NUM_SETPOINTS; i++) begin
        s = st_r.sp[i];
        if (s.cfg.en && s.cfg.chan == sample_in.chan) begin
          crit_ok = 1'b0;
          do_upd = 1'b0;
          val = s.val_true;
          unique case (s.cfg.crit)
            CRIT_EQUAL: crit_ok = (x == s.limit_hi);
            CRIT_BELOW: crit_ok = (x < s.limit_hi);
            CRIT_ABOVE: crit_ok = (x > s.limit_lo);
            CRIT_INSIDE: crit_ok = (x > s.limit_lo) && (x < s.limit_hi);
            CRIT_OUTSIDE: crit_ok = (x > s.limit_hi) || (x < s.limit_lo);
            CRIT_HYST: begin
              crit_ok = st_r.hyst_hi[i];
              if (x > s.limit_hi) begin
                crit_ok = 1'b1;
                do_upd = 1'b1;
                val = s.val_false;
              end else if (x < s.limit_lo) begin
                crit_ok = 1'b0;
                do_upd = 1'b1;
                val = s.val_true;
              end
              st_nxt.hyst_hi[i] = crit_ok;
            end
            default: crit_ok = 1'b0;
          endcase
          st_nxt.flag[i] = crit_ok;
          if (s.cfg.crit != CRIT_HYST) begin
            if (s.cfg.upd == UPD_TRUE_ONLY) begin
              do_upd = crit_ok;
            end else if (s.cfg.upd == UPD_TRUE_FALSE) begin
              do_upd = 1'b1;
              val = crit_ok ? s.val_true : s.val_false;
            end
          end
          if (s.cfg.upd == UPD_NONE) begin
            do_upd = 1'b0;
          end
          if (do_upd) begin
            unique case (s.cfg.act)
              ACT_NONE: hit = 1'b0;
              ACT_PORT: st_nxt.port = (st_nxt.port & ~val[15:8]) | (val[7:0] & val[15:8]);
              ACT_DAC: begin
                st_nxt.dac[s.cfg.sel] = val;
                st_nxt.dac_stb[s.cfg.sel] = 1'b1;
              end
              ACT_TIMER: begin
                st_nxt.tmr.valid = 1'b1;
                st_nxt.tmr.sel = s.cfg.sel;
                st_nxt.tmr.value = val;
              end
            endcase
          end
        end
      end
    end

    // Register reads, data in the following cycle
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        st_nxt.rdata = {30'h0, st_r.port_oe, st_r.armed};
      end else if (reg_addr == REG_STATUS) begin
        st_nxt.rdata = {16'h0, st_r.flag};
      end else if (reg_addr == REG_PORT_DATA) begin
        st_nxt.rdata = {24'h0, st_r.port};
      end else if (reg_addr >= REG_DAC_BASE && reg_addr < REG_DAC_BASE + 8'(NUM_DAC)) begin
        st_nxt.rdata = {16'h0, st_r.dac[reg_addr[1:0]]};
      end else if (reg_addr >= REG_SP_BASE) begin
        idx = 4'(reg_addr - REG_SP_BASE >> SP_STRIDE_LOG2);
        unique case (fld)
          SP_CFG: st_nxt.rdata = {14'h0, st_r.sp[idx].cfg};
          SP_LIMIT_HI: st_nxt.rdata = {16'h0, st_r.sp[idx].limit_hi};
          SP_LIMIT_LO: st_nxt.rdata = {16'h0, st_r.sp[idx].limit_lo};
          SP_VAL_TRUE: st_nxt.rdata = {16'h0, st_r.sp[idx].val_true};
          SP_VAL_FALSE: st_nxt.rdata = {16'h0, st_r.sp[idx].val_false};
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
      st_r.port <= RST_PORT;
      st_r.dac <= {NUM_DAC{RST_DAC}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign channel_match_flag = st_r.flag;
  assign byte_output_port = st_r.port;
  assign byte_output_port_oe = {8{st_r.port_oe}};
  assign analog_output_n = st_r.dac;
  assign analog_output_strobe = st_r.dac_stb;
  assign timer_update = st_r.tmr;

endmodule
`default_nettype wire

// ===== verification/scan_source.sv
// Scan data path model: delivers one channel sample per call
`timescale 1ns/100ps
`default_nettype none
module scan_source
  import setpoint_pkg::*;
(
  input wire logic mclk,
  output var sample_t sample_in
);
  initial sample_in = '0;
  // One-cycle valid per channel sample, lines scrambled between samples
  task automatic send(input logic [7:0] ch, input logic [15:0] d);
    @(posedge mclk);
    sample_in <= '{1'b1, ch, d};
    @(posedge mclk);
    sample_in <= '{1'b0, ~ch, ~d};
    #1;
  endtask
endmodule
`default_nettype wire

// ===== verification/setpoint_detect_update_checker.sv
// Port checker for the setpoint detect engine
`timescale 1ns/100ps
`default_nettype none
module setpoint_detect_update_checker
  import setpoint_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire sample_t sample_in,
  input wire logic [NUM_SETPOINTS-1:0] channel_match_flag,
  input wire logic [7:0] byte_output_port,
  input wire logic [7:0] byte_output_port_oe,
  input wire logic [NUM_DAC-1:0][15:0] analog_output_n,
  input wire logic [NUM_DAC-1:0] analog_output_strobe,
  input wire timer_upd_t timer_update
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence took_s; sample_in.valid; endsequence
  sequence disarm_s; reg_wr && reg_addr == REG_CTRL && !reg_wdata[CTRL_ARM_BIT]; endsequence
  sequence stat_s; reg_rd && reg_addr == REG_STATUS; endsequence
  flag_hold_a:
    assert property (!sample_in.valid |=> $stable(channel_match_flag)) else $error("flag moved without sample");
  rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read slot");
  status_read_a:
    assert property (stat_s |=> reg_rdata[15:0] == $past(channel_match_flag)) else $error("status differs");
  port_cause_a:
    assert property (!$stable(byte_output_port) |-> $past(sample_in.valid) || $past(reg_wr)) else $error("port moved");
  oe_cause_a:
    assert property (!$stable(byte_output_port_oe) |-> $past(reg_wr)) else $error("port enable moved");
  oe_whole_a:
    assert property (byte_output_port_oe == 8'h00 || byte_output_port_oe == 8'hff) else $error("split enable");
  dac_strobe_a:
    assert property (!$stable(analog_output_n) |-> analog_output_strobe != 4'h0) else $error("dac without strobe");
  strobe_cause_a:
    assert property (analog_output_strobe != 4'h0 |-> $past(sample_in.valid) || $past(reg_wr)) else $error("stray strobe");
  timer_cause_a:
    assert property (timer_update.valid |-> $past(sample_in.valid)) else $error("stray timer update");
  disarm_hold_a:
    assert property (disarm_s ##[1:3] took_s |=> $stable(channel_match_flag)) else $error("disarmed flag moved");
endmodule
bind setpoint_detect_update setpoint_detect_update_checker chk_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_in(sample_in),
  .channel_match_flag(channel_match_flag), .byte_output_port(byte_output_port),
  .byte_output_port_oe(byte_output_port_oe), .analog_output_n(analog_output_n),
  .analog_output_strobe(analog_output_strobe), .timer_update(timer_update));
`default_nettype wire

// ===== verification/tb_setpoint_detect_update.sv
// Testbench for the setpoint detect engine
`timescale 1ns/100ps
`default_nettype none
module tb_setpoint_detect_update;
  import setpoint_pkg::*;
  typedef struct packed {crit_t c; logic [15:0] s; logic f;} row_t;
  logic mclk, rst, reg_wr, reg_rd;
  logic [7:0] reg_addr, port, oe;
  logic [31:0] reg_wdata, reg_rdata, exp;
  logic [2:0] last;
  sample_t sample_in;
  logic [NUM_SETPOINTS-1:0] flag;
  logic [NUM_DAC-1:0][15:0] dac;
  logic [NUM_DAC-1:0] stb;
  timer_upd_t tmr;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  row_t rows [16] = '{
    '{CRIT_EQUAL, 16'h1000, 1'b1}, '{CRIT_EQUAL, 16'h0fff, 1'b0},
    '{CRIT_BELOW, 16'h0fff, 1'b1}, '{CRIT_BELOW, 16'h1000, 1'b0},
    '{CRIT_ABOVE, 16'h0801, 1'b1}, '{CRIT_ABOVE, 16'h0800, 1'b0},
    '{CRIT_INSIDE, 16'h0801, 1'b1}, '{CRIT_INSIDE, 16'h1000, 1'b0}, '{CRIT_INSIDE, 16'h0800, 1'b0},
    '{CRIT_OUTSIDE, 16'h1001, 1'b1}, '{CRIT_OUTSIDE, 16'h07ff, 1'b1}, '{CRIT_OUTSIDE, 16'h1000, 1'b0},
    '{CRIT_HYST, 16'h1001, 1'b1}, '{CRIT_HYST, 16'h0900, 1'b1},
    '{CRIT_HYST, 16'h07ff, 1'b0}, '{CRIT_HYST, 16'h0900, 1'b0}};
  setpoint_detect_update dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_in(sample_in), .channel_match_flag(flag),
    .byte_output_port(port), .byte_output_port_oe(oe), .analog_output_n(dac), .analog_output_strobe(stb),
    .timer_update(tmr));
  scan_source src_u (.mclk(mclk), .sample_in(sample_in));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, want);
  endtask
  function automatic logic [31:0] mk(input logic [7:0] ch, input crit_t c, input upd_t u, input act_t a,
                                     input logic [1:0] s);
    return {14'h0, 1'b1, s, a, u, c, ch};
  endfunction
  // Writes cfg, limits and both update values of one setpoint
  task automatic setp(input int i, input logic [31:0] cfg, input logic [15:0] hi, lo, vt, vf);
    logic [31:0] v [5];
    v = '{cfg, 32'(hi), 32'(lo), 32'(vt), 32'(vf)};
    for (int k = 0; k < 5; k++) begin
      wr(8'(REG_SP_BASE + 8'(i * 8) + 8'(k)), v[k]);
    end
  endtask
  task automatic stop_test();
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    last = 3'h7;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check(32'(oe), 32'h0);
    check({31'h0, |dac}, 32'h0);
    wr(8'(REG_DAC_BASE + 8'h2), 32'h0abc);
    check(32'(dac[2]), 32'h0abc);
    wr(REG_PORT_DATA, 32'h5a);
    check({16'h0, oe, port}, 32'hff5a);
    for (int k = 0; k < 16; k++) begin
      if (rows[k].c != last) begin
        wr(REG_CTRL, 32'h2);
        setp(0, mk(8'h03, rows[k].c, UPD_TRUE_FALSE, ACT_DAC, 2'h1), 16'h1000, 16'h0800, 16'h0111, 16'h0222);
        wr(REG_CTRL, 32'h3);
        last = rows[k].c;
      end
      src_u.send(8'h03, rows[k].s);
      check(32'(flag[0]), 32'(rows[k].f));
      exp = ((rows[k].c == CRIT_HYST) ^ rows[k].f) ? 32'h0111 : 32'h0222;
      check(32'(dac[1]), exp);
    end
    wr(REG_CTRL, 32'h2);
    setp(1, mk(8'h07, CRIT_ABOVE, UPD_TRUE_ONLY, ACT_PORT, 2'h0), 16'h0, 16'h0100, 16'h0f03, 16'h0);
    setp(2, mk(8'h09, CRIT_BELOW, UPD_TRUE_FALSE, ACT_TIMER, 2'h2), 16'h0010, 16'h0, 16'h1234, 16'h4321);
    setp(3, mk(8'h0b, CRIT_EQUAL, UPD_NONE, ACT_DAC, 2'h0), 16'h0042, 16'h0, 16'h0777, 16'h0888);
    wr(REG_CTRL, 32'h3);
    src_u.send(8'h07, 16'h0200);
    check(32'(port), 32'h53);
    src_u.send(8'h07, 16'h0050);
    check(32'(port), 32'h53);
    src_u.send(8'h09, 16'h0005);
    check(32'(tmr), 32'h61234);
    src_u.send(8'h09, 16'h0020);
    check(32'(tmr), 32'h64321);
    src_u.send(8'h0b, 16'h0042);
    check({11'h0, flag[3], stb, dac[0]}, 32'h100000);
    rd(REG_STATUS, 32'h8);
    rd(8'h03, 32'h0);
    wr(REG_CTRL, 32'h2);
    src_u.send(8'h0b, 16'h0000);
    check(32'(flag[3]), 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
